// ==== dcx_consts.svh ====
// constants for the tri-level one-wire pull-value link: timing, frame layout, register addresses
// assumes a 20 MHz clk on both ends; included by dcx_pkg users and both link ends
//
// Contract
// - device ignores frames until power-up sequence completes
// - two-frame mode: apply only after second frame
// - two-frame mode holds a 23-bit pull value
// - master sends low-word frame first, upper bits zero
// - master sends 16-bit high word as second frame
// - scale factor: max code over range times correction
// - code is rounded absolute ppm times scale
// - negative shifts sent as two's complement
// - 40-bit frames MSB first: header, address, data
// - one is high then middle, zero low then middle
// - single-frame mode: one high-word frame updates immediately
// - at least 2 us between frames
`ifndef DCX_CONSTS_SVH
`define DCX_CONSTS_SVH

`define DCX_CLK_MHZ 20
`define DCX_T_LOGIC_NS 500
`define DCX_T_MIDDLE_NS 500
`define DCX_T_GAP_NS 2000
`define DCX_LOGIC_CYC ((`DCX_T_LOGIC_NS * `DCX_CLK_MHZ + 999) / 1000)
`define DCX_MIDDLE_CYC ((`DCX_T_MIDDLE_NS * `DCX_CLK_MHZ + 999) / 1000)
`define DCX_GAP_CYC ((`DCX_T_GAP_NS * `DCX_CLK_MHZ + 999) / 1000)
`define DCX_PWRUP_CYC 64
`define DCX_MID_MAX_CYC 200

`define DCX_FRAME_BITS 40
`define DCX_HDR_HI 8'hFA
`define DCX_HDR_LO 4'hA
`define DCX_REG_HIGH 8'h06
`define DCX_REG_LOW 8'h07
`define DCX_LOW_BITS 7
`define DCX_PULL_BITS 23

`define DCX_APB_CTRL 12'h000
`define DCX_APB_PULL 12'h004
`define DCX_APB_STAT 12'h008
`define DCX_CTRL_MODE2 0
`define DCX_CTRL_ADDR_LSB 4
`define DCX_STAT_BUSY 0
`define DCX_STAT_ERR 1

`endif

// ==== dcx_pkg.sv ====
// types shared by both ends of the pull-value link
// assumes dcx_consts.svh for all figures
package dcx_pkg;
	typedef enum logic [1:0] {
		DCX_RX_BOOT = 2'b00,
		DCX_RX_WAIT = 2'b01,
		DCX_RX_DRV = 2'b10,
		DCX_RX_MID = 2'b11
	} dcx_rx_state_t;
	typedef enum logic [1:0] {
		DCX_TX_IDLE = 2'b00,
		DCX_TX_DRV = 2'b01,
		DCX_TX_MID = 2'b10,
		DCX_TX_GAP = 2'b11
	} dcx_tx_state_t;
endpackage : dcx_pkg

// ==== dcx_link_if.sv ====
// program_line carrier: master drives high or low with enable, released line sits at middle level
// assumes the bench joins master and device ends through this interface
`timescale 1ns/10ps
interface dcx_link_if;
	logic program_line_o;
	logic program_line_oe;
	modport master (output program_line_o, output program_line_oe);
	modport device (input program_line_o, input program_line_oe);
endinterface : dcx_link_if

// ==== dcx_pull_rx.sv ====
// device end: decodes tri-level frames and presents the oscillator pull value
// assumes line inputs synchronous to clk; oscillator analog side is outside
`timescale 1ns/10ps
`include "dcx_consts.svh"
module dcx_pull_rx import dcx_pkg::*; #(
	parameter int PWRUP_CYC = `DCX_PWRUP_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// link
	dcx_link_if.device link,
	// configuration straps
	input wire logic [3:0] dev_addr,
	input wire logic mode_two_frame,
	// oscillator side
	output logic rx_ready,
	output logic signed [`DCX_PULL_BITS-1:0] pull_frequency_value,
	output logic pull_two_frame,
	output logic pull_update,
	output logic frame_error
);
	localparam int W = `DCX_PULL_BITS;
	localparam int NF = `DCX_FRAME_BITS;
	// longest middle level accepted inside a frame; beyond it the master is taken to have given up
	localparam int MID_MAX = `DCX_MID_MAX_CYC;

	dcx_rx_state_t st_r, st_nxt;
	logic [15:0] pcnt_r, pcnt_nxt;
	logic [7:0] wcnt_r, wcnt_nxt;
	logic [5:0] bcnt_r, bcnt_nxt;
	logic [NF-1:0] sr_r, sr_nxt;
	logic bit_r, bit_nxt;
	logic [`DCX_LOW_BITS-1:0] low_r, low_nxt;
	logic low_vld_r, low_vld_nxt;
	logic signed [W-1:0] pull_r, pull_nxt;
	logic mode2_r, mode2_nxt;
	logic upd_r, upd_nxt;
	logic err_r, err_nxt;

	logic [NF-1:0] frame;
	logic hdr_ok;
	logic [7:0] reg_addr;
	logic [15:0] data;

	always_comb begin
		frame = {sr_r[NF-2:0], bit_r};
		// header 0xFA, device address, 0xA, then register address and data, msb first
		hdr_ok = (frame[39:32] == `DCX_HDR_HI) && (frame[31:28] == dev_addr) && (frame[27:24] == `DCX_HDR_LO);
		reg_addr = frame[23:16];
		data = frame[15:0];
	end

	always_comb begin
		st_nxt = st_r;
		pcnt_nxt = pcnt_r;
		wcnt_nxt = (wcnt_r == 8'hFF) ? wcnt_r : wcnt_r + 8'h01;
		bcnt_nxt = bcnt_r;
		sr_nxt = sr_r;
		bit_nxt = bit_r;
		low_nxt = low_r;
		low_vld_nxt = low_vld_r;
		pull_nxt = pull_r;
		mode2_nxt = mode2_r;
		upd_nxt = 1'b0;
		err_nxt = 1'b0;
		case (st_r)
			DCX_RX_BOOT: begin
				// line activity during power-up is not a frame; leave only after a full idle gap
				if (link.program_line_oe) begin
					// any drive restarts the idle count, so a frame already under way is skipped whole
					wcnt_nxt = 8'h00;
				end
				if (pcnt_r < PWRUP_CYC[15:0]) begin
					pcnt_nxt = pcnt_r + 16'h0001;
				end else if (!link.program_line_oe && wcnt_r >= 8'(`DCX_GAP_CYC)) begin
					st_nxt = DCX_RX_WAIT;
				end
			end
			DCX_RX_WAIT: begin
				// a frame may only start after a full gap, so a stray bit cannot shift the framing
				if (link.program_line_oe && wcnt_r >= 8'(`DCX_GAP_CYC)) begin
					st_nxt = DCX_RX_DRV;
					bit_nxt = link.program_line_o;
					wcnt_nxt = 8'h01;
				end else if (link.program_line_oe) begin
					wcnt_nxt = 8'h00;
				end
			end
			DCX_RX_DRV: begin
				if (link.program_line_oe && (link.program_line_o != bit_r)) begin
					// a switch between high and low with no middle level is no symbol; drop the partial frame
					err_nxt = 1'b1;
					bcnt_nxt = 6'd0;
					st_nxt = DCX_RX_WAIT;
					wcnt_nxt = 8'h00;
				end else if (!link.program_line_oe) begin
					st_nxt = DCX_RX_MID;
					wcnt_nxt = 8'h01;
					if (wcnt_r < 8'(`DCX_LOGIC_CYC)) begin
						// line-timing errors fall back to hunting for a gap, which regains the framing; bad frame contents do not
						err_nxt = 1'b1;
						bcnt_nxt = 6'd0;
						st_nxt = DCX_RX_WAIT;
					end else if (bcnt_r == 6'(NF - 1)) begin
						// symbol ends at the middle level: high=1, low=0
						bcnt_nxt = 6'd0;
						if (!hdr_ok) begin
							err_nxt = !(frame[39:32] == `DCX_HDR_HI && frame[27:24] == `DCX_HDR_LO);
						end else if (reg_addr == `DCX_REG_LOW && mode2_r) begin
							// low word: only seven bits meaningful, rest must be zero
							if (data[15:`DCX_LOW_BITS] != '0) begin
								err_nxt = 1'b1;
								low_vld_nxt = 1'b0;
							end else begin
								low_nxt = data[`DCX_LOW_BITS-1:0];
								low_vld_nxt = 1'b1;
							end
						end else if (reg_addr == `DCX_REG_HIGH && mode2_r) begin
							// second frame completes the 23-bit value and applies it
							if (low_vld_r) begin
								pull_nxt = {data, low_r};
								upd_nxt = 1'b1;
							end else begin
								err_nxt = 1'b1;
							end
							low_vld_nxt = 1'b0;
						end else if (reg_addr == `DCX_REG_HIGH) begin
							// single frame, sign-extended two's complement
							pull_nxt = W'(signed'(data));
							upd_nxt = 1'b1;
						end else begin
							err_nxt = 1'b1;
						end
					end else begin
						sr_nxt = frame;
						bcnt_nxt = bcnt_r + 6'd1;
					end
				end
			end
			DCX_RX_MID: begin
				if (link.program_line_oe) begin
					st_nxt = DCX_RX_DRV;
					bit_nxt = link.program_line_o;
					wcnt_nxt = 8'h01;
					if (wcnt_r < 8'(`DCX_MIDDLE_CYC)) begin
						err_nxt = 1'b1;
						bcnt_nxt = 6'd0;
						st_nxt = DCX_RX_WAIT;
						wcnt_nxt = 8'h00;
					end
				end else if (bcnt_r != 6'd0 && wcnt_r >= 8'(MID_MAX)) begin
					// a cut frame is dropped rather than spliced onto the start of the next one
					err_nxt = 1'b1;
					bcnt_nxt = 6'd0;
					st_nxt = DCX_RX_WAIT;
				end
			end
			default: begin
				st_nxt = DCX_RX_BOOT;
			end
		endcase
		// mode is latched only between frames, including inside a pair; a change discards any held low word
		if ((st_r == DCX_RX_WAIT || st_r == DCX_RX_MID) && bcnt_r == 6'd0 && mode2_r != mode_two_frame) begin
			mode2_nxt = mode_two_frame;
			low_vld_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= DCX_RX_BOOT;
			pcnt_r <= 16'h0000;
			wcnt_r <= 8'h00;
			bcnt_r <= 6'd0;
			sr_r <= '0;
			bit_r <= 1'b0;
			low_r <= '0;
			low_vld_r <= 1'b0;
			pull_r <= '0;
			mode2_r <= 1'b0;
			upd_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			pcnt_r <= pcnt_nxt;
			wcnt_r <= wcnt_nxt;
			bcnt_r <= bcnt_nxt;
			sr_r <= sr_nxt;
			bit_r <= bit_nxt;
			low_r <= low_nxt;
			low_vld_r <= low_vld_nxt;
			pull_r <= pull_nxt;
			mode2_r <= mode2_nxt;
			upd_r <= upd_nxt;
			err_r <= err_nxt;
		end
	end

	always_comb begin
		rx_ready = (st_r != DCX_RX_BOOT);
		pull_frequency_value = pull_r;
		pull_two_frame = mode2_r;
		pull_update = upd_r;
		frame_error = err_r;
	end
endmodule : dcx_pull_rx

// ==== dcx_pull_tx.sv ====
// master end: APB registers take a pull code and send it as one or two frames
// assumes APB master on the same clk; software computes the code (scale, rounding, sign)
`timescale 1ns/10ps
`include "dcx_consts.svh"
module dcx_pull_tx import dcx_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// link
	dcx_link_if.master link
);
	// code scaling and two's complement are done by software before the write
	dcx_tx_state_t st_r, st_nxt;
	logic [7:0] tcnt_r, tcnt_nxt;
	logic [5:0] bcnt_r, bcnt_nxt;
	logic [39:0] sr_r, sr_nxt;
	logic second_r, second_nxt;
	logic tail_r, tail_nxt;
	logic mode2_r, mode2_nxt;
	logic [3:0] addr_r, addr_nxt;
	logic [22:0] pull_r, pull_nxt;
	logic err_r, err_nxt;
	logic line_o_r, line_o_nxt;
	logic line_oe_r, line_oe_nxt;
	logic [31:0] rd_r, rd_nxt;

	logic wr, rd, hit, busy;
	logic [39:0] frame_low, frame_high;

	always_comb begin
		busy = (st_r != DCX_TX_IDLE);
		wr = psel && penable && pwrite;
		rd = psel && !penable && !pwrite;
		hit = (paddr == `DCX_APB_CTRL) || (paddr == `DCX_APB_PULL) || (paddr == `DCX_APB_STAT);
		// low word first with upper bits zero then the 16-bit high word
		frame_low = {`DCX_HDR_HI, addr_r, `DCX_HDR_LO, `DCX_REG_LOW, 9'h000, pull_r[6:0]};
		frame_high = {`DCX_HDR_HI, addr_r, `DCX_HDR_LO, `DCX_REG_HIGH, mode2_r ? pull_r[22:7] : pull_r[15:0]};
	end

	always_comb begin
		st_nxt = st_r;
		tcnt_nxt = (tcnt_r == 8'h00) ? 8'h00 : tcnt_r - 8'h01;
		bcnt_nxt = bcnt_r;
		sr_nxt = sr_r;
		second_nxt = second_r;
		tail_nxt = tail_r;
		mode2_nxt = mode2_r;
		addr_nxt = addr_r;
		pull_nxt = pull_r;
		err_nxt = err_r;
		line_o_nxt = line_o_r;
		line_oe_nxt = line_oe_r;
		rd_nxt = rd_r;
		if (rd) begin
			case (paddr)
				`DCX_APB_CTRL: rd_nxt = {24'h000000, addr_r, 3'b000, mode2_r};
				`DCX_APB_PULL: rd_nxt = {9'h000, pull_r};
				`DCX_APB_STAT: rd_nxt = {30'h00000000, err_r, busy};
				default: rd_nxt = 32'h00000000;
			endcase
		end
		if (wr && paddr == `DCX_APB_CTRL && !busy) begin
			mode2_nxt = pwdata[`DCX_CTRL_MODE2];
			addr_nxt = pwdata[`DCX_CTRL_ADDR_LSB+3:`DCX_CTRL_ADDR_LSB];
		end
		// a pull write while busy is dropped and flagged; write 1 to status error bit clears it
		if (wr && paddr == `DCX_APB_STAT && pwdata[`DCX_STAT_ERR]) begin
			err_nxt = 1'b0;
		end
		if (wr && paddr == `DCX_APB_PULL && busy) begin
			err_nxt = 1'b1;
		end
		case (st_r)
			DCX_TX_IDLE: begin
				if (wr && paddr == `DCX_APB_PULL) begin
					pull_nxt = pwdata[22:0];
					st_nxt = DCX_TX_GAP;
					tcnt_nxt = 8'h00;
					bcnt_nxt = 6'd0;
					second_nxt = mode2_r;
				end
			end
			DCX_TX_GAP: begin
				// gap before the second frame, with the trailing gap after the last, keeps frames 2 us apart
				line_oe_nxt = 1'b0;
				if (tcnt_r == 8'h00 && tail_r) begin
					// trailing gap served, so a new code cannot follow the last frame too closely
					tail_nxt = 1'b0;
					st_nxt = DCX_TX_IDLE;
				end else if (tcnt_r == 8'h00) begin
					sr_nxt = second_r ? frame_low : frame_high;
					st_nxt = DCX_TX_DRV;
					line_oe_nxt = 1'b1;
					line_o_nxt = second_r ? frame_low[39] : frame_high[39];
					tcnt_nxt = 8'(`DCX_LOGIC_CYC - 1);
				end
			end
			DCX_TX_DRV: begin
				// drive high for one, low for zero, msb first
				if (tcnt_r == 8'h00) begin
					line_oe_nxt = 1'b0;
					st_nxt = DCX_TX_MID;
					tcnt_nxt = 8'(`DCX_MIDDLE_CYC - 1);
				end
			end
			DCX_TX_MID: begin
				if (tcnt_r == 8'h00) begin
					if (bcnt_r == 6'd39) begin
						bcnt_nxt = 6'd0;
						if (second_r) begin
							second_nxt = 1'b0;
							st_nxt = DCX_TX_GAP;
							tcnt_nxt = 8'(`DCX_GAP_CYC - 1);
						end else begin
							// after the last frame the trailing gap is served before going idle
							st_nxt = DCX_TX_GAP;
							tcnt_nxt = 8'(`DCX_GAP_CYC - 1);
							tail_nxt = 1'b1;
						end
					end else begin
						bcnt_nxt = bcnt_r + 6'd1;
						sr_nxt = {sr_r[38:0], 1'b0};
						line_oe_nxt = 1'b1;
						line_o_nxt = sr_r[38];
						st_nxt = DCX_TX_DRV;
						tcnt_nxt = 8'(`DCX_LOGIC_CYC - 1);
					end
				end
			end
			default: begin
				st_nxt = DCX_TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= DCX_TX_IDLE;
			tcnt_r <= 8'h00;
			bcnt_r <= 6'd0;
			sr_r <= 40'h0000000000;
			second_r <= 1'b0;
			tail_r <= 1'b0;
			mode2_r <= 1'b0;
			addr_r <= 4'h0;
			pull_r <= 23'h000000;
			err_r <= 1'b0;
			line_o_r <= 1'b0;
			line_oe_r <= 1'b0;
			rd_r <= 32'h00000000;
		end else begin
			st_r <= st_nxt;
			tcnt_r <= tcnt_nxt;
			bcnt_r <= bcnt_nxt;
			sr_r <= sr_nxt;
			second_r <= second_nxt;
			tail_r <= tail_nxt;
			mode2_r <= mode2_nxt;
			addr_r <= addr_nxt;
			pull_r <= pull_nxt;
			err_r <= err_nxt;
			line_o_r <= line_o_nxt;
			line_oe_r <= line_oe_nxt;
			rd_r <= rd_nxt;
		end
	end

	always_comb begin
		prdata = rd_r;
		pready = 1'b1;
		pslverr = psel && penable && !hit;
		link.program_line_o = line_o_r;
		link.program_line_oe = line_oe_r;
	end
endmodule : dcx_pull_tx

// ==== dcx_link_chk.sv ====
// checker for the program_line wire between the two link ends
// assumes clk/rst_b of both ends and the interface signals wired in by name
`timescale 1ns/10ps
`include "dcx_consts.svh"
module dcx_link_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// link wire
	input wire logic program_line_o,
	input wire logic program_line_oe
);
	logic oe_q_r, seen_r, done_r;
	logic [7:0] hi_cnt_r, lo_cnt_r, last_reg_r;
	logic [5:0] bit_cnt_r;
	logic [39:0] sh_r;
	wire rise = program_line_oe && !oe_q_r;
	wire fall = !program_line_oe && oe_q_r;
	// lo_cnt saturates so long idle spans never wrap below the gap figure
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			oe_q_r <= 1'b0;
			seen_r <= 1'b0;
			done_r <= 1'b0;
			hi_cnt_r <= 8'h00;
			lo_cnt_r <= 8'h00;
			last_reg_r <= 8'h00;
			bit_cnt_r <= 6'h00;
			sh_r <= 40'h0;
		end else begin
			oe_q_r <= program_line_oe;
			done_r <= rise && bit_cnt_r == 6'd39;
			if (program_line_oe) hi_cnt_r <= oe_q_r ? hi_cnt_r + 8'h01 : 8'h01;
			else lo_cnt_r <= oe_q_r ? 8'h01 : (lo_cnt_r == 8'hFF ? lo_cnt_r : lo_cnt_r + 8'h01);
			if (rise) begin
				sh_r <= {sh_r[38:0], program_line_o};
				bit_cnt_r <= bit_cnt_r == 6'd39 ? 6'd0 : bit_cnt_r + 6'd1;
			end
			if (done_r) begin
				last_reg_r <= sh_r[23:16];
				seen_r <= 1'b1;
			end
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_drive_len: assert property (fall |-> hi_cnt_r == `DCX_LOGIC_CYC)
		else $error("drive phase length wrong");
	a_bit_steady: assert property (program_line_oe && oe_q_r |-> $stable(program_line_o))
		else $error("bit level changed while driven");
	a_mid_len: assert property (rise && bit_cnt_r != 6'd0 |-> lo_cnt_r == `DCX_MIDDLE_CYC)
		else $error("middle phase length wrong");
	a_bit_follows: assert property (fall && bit_cnt_r != 6'd0 |-> ##10 program_line_oe)
		else $error("frame stopped before 40 bits");
	a_frame_gap: assert property (rise && bit_cnt_r == 6'd0 && seen_r |-> lo_cnt_r >= `DCX_GAP_CYC)
		else $error("gap between frames too short");
	a_header_fixed: assert property (done_r |-> sh_r[39:32] == `DCX_HDR_HI && sh_r[27:24] == `DCX_HDR_LO)
		else $error("frame header pattern wrong");
	a_reg_known: assert property (done_r |-> sh_r[23:16] == `DCX_REG_HIGH || sh_r[23:16] == `DCX_REG_LOW)
		else $error("frame register address unknown");
	a_low_upper_zero: assert property (done_r && sh_r[23:16] == `DCX_REG_LOW |-> sh_r[15:7] == 9'h000)
		else $error("low word upper bits not zero");
	a_pair_order: assert property (done_r && seen_r && last_reg_r == `DCX_REG_LOW |-> sh_r[23:16] == `DCX_REG_HIGH)
		else $error("low word not followed by high word");
	c_low_frame: cover property (done_r && sh_r[23:16] == `DCX_REG_LOW);
	c_high_frame: cover property (done_r && sh_r[23:16] == `DCX_REG_HIGH);
	c_gap: cover property (rise && bit_cnt_r == 6'd0 && seen_r);
endmodule : dcx_link_chk

// ==== dcx_pull_value_frame_link_tb.sv ====
// bench: APB master end sends pull codes to the device end over program_line
// assumes design files and dcx_link_chk.sv compiled first; 20 MHz clk
`timescale 1ns/10ps
`include "dcx_consts.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module dcx_pull_value_frame_link_tb;
	logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, rx_ready, pull_two_frame, pull_update, frame_error;
	logic [3:0] dev_addr = 4'h0;
	logic mode_two_frame = 1'b0;
	logic signed [`DCX_PULL_BITS-1:0] pull_frequency_value;
	logic [22:0] m2v [4] = '{23'h5B3DEA, 23'h3FFFFF, 23'h400000, 23'h000081};
	int num_errors = 0, n_checks = 0, n_upd = 0, n_ferr = 0, cyc = 0, u;
	dcx_link_if dcx_link_if_inst ();
	dcx_pull_tx dcx_pull_tx_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(dcx_link_if_inst));
	dcx_pull_rx dcx_pull_rx_inst (.clk(clk), .rst_b(rst_b), .link(dcx_link_if_inst), .dev_addr(dev_addr),
		.mode_two_frame(mode_two_frame), .rx_ready(rx_ready), .pull_frequency_value(pull_frequency_value),
		.pull_two_frame(pull_two_frame), .pull_update(pull_update), .frame_error(frame_error));
	dcx_link_chk dcx_link_chk_inst (.clk(clk), .rst_b(rst_b), .program_line_o(dcx_link_if_inst.program_line_o),
		.program_line_oe(dcx_link_if_inst.program_line_oe));
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (pull_update === 1'b1) n_upd++;
		if (frame_error === 1'b1) n_ferr++;
		if (cyc == 40000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic summarize;
		if (num_errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	// entered right after a rising edge; leaves one idle edge so psel never moves twice at once
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wait_idle;
		for (int i = 0; i < 1000; i++) begin
			apb(1'b0, `DCX_APB_STAT, 32'h0);
			if (rd[`DCX_STAT_BUSY] === 1'b0) return;
		end
		num_errors++;
	endtask : wait_idle
	task automatic send(input logic m2, input logic [3:0] ad, input logic [22:0] v, input int nu);
		int u0;
		u0 = n_upd;
		apb(1'b1, `DCX_APB_CTRL, {24'h0, ad, 3'h0, m2});
		apb(1'b1, `DCX_APB_PULL, {9'h0, v});
		wait_idle();
		`CHK("updates", nu, n_upd - u0)
		if (nu > 0) `CHK("pull value", (m2 ? v : {{7{v[15]}}, v[15:0]}), pull_frequency_value)
		if (nu > 0) `CHK("mode", m2, pull_two_frame)
	endtask : send
	initial begin
		repeat (3) @(posedge clk);
		`CHK("ready in reset", 1'b0, rx_ready)
		`CHK("pull in reset", 23'h0, pull_frequency_value)
		rst_b <= 1'b1;
		@(posedge clk);
		apb(1'b0, `DCX_APB_CTRL, 32'h0);
		`CHK("ctrl reset", 32'h0, rd)
		send(1'b0, 4'h0, 23'h001234, 0);
		`CHK("ready", 1'b1, rx_ready)
		send(1'b0, 4'h0, 23'h00099C, 1);
		send(1'b0, 4'h0, 23'h00F000, 1);
		send(1'b0, 4'h5, 23'h000123, 0);
		`CHK("other address", 23'h7FF000, pull_frequency_value)
		apb(1'b1, `DCX_APB_CTRL, 32'h0);
		apb(1'b1, `DCX_APB_PULL, 32'h00000456);
		apb(1'b0, `DCX_APB_STAT, 32'h0);
		`CHK("busy", 1'b1, rd[`DCX_STAT_BUSY])
		// a second code while busy must not disturb the frame in flight
		apb(1'b1, `DCX_APB_PULL, 32'h00000789);
		wait_idle();
		`CHK("err flag", 1'b1, rd[`DCX_STAT_ERR])
		`CHK("kept value", 23'h000456, pull_frequency_value)
		apb(1'b1, `DCX_APB_STAT, 32'h2);
		apb(1'b0, `DCX_APB_STAT, 32'h0);
		`CHK("stat clear", 32'h0, rd)
		apb(1'b0, 12'h00C, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		mode_two_frame <= 1'b1;
		u = n_ferr;
		send(1'b0, 4'h0, 23'h000111, 0);
		`CHK("lone high word", 1, n_ferr - u)
		foreach (m2v[i]) send(1'b1, 4'h0, m2v[i], 1);
		summarize();
	end
endmodule : dcx_pull_value_frame_link_tb
